/* core/mac_irq_pkg.sv */
// constants and carrier types for the mac interrupt logic
// assumes one system clock domain shared with the mac, mmu and phy serial logic
package mac_irq_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FLAG_W = 8;
  localparam int unsigned PHY_STATUS_W = 9;
  localparam int unsigned TX_CAUSE_W = 4;

  // byte offsets; the flag/ack byte shares a word with the mask byte
  localparam logic [ADDR_W-1:0] EVENT_FLAG_OFFSET = 4'hc;
  localparam logic [ADDR_W-1:0] INTERRUPT_ENABLE_MASK_OFFSET = 4'hd;

  // bit positions inside the flag, ack and mask bytes
  localparam int unsigned RECEIVE_PENDING_BIT = 0;
  localparam int unsigned TX_COMPLETE_BIT = 1;
  localparam int unsigned TX_DRAINED_BIT = 2;
  localparam int unsigned ALLOCATION_DONE_BIT = 3;
  localparam int unsigned RECEIVE_ABORT_BIT = 4;
  localparam int unsigned PROTOCOL_EXCEPTION_BIT = 5;
  localparam int unsigned RESERVED_BIT = 6;
  localparam int unsigned PHY_STATUS_CHANGE_BIT = 7;

  // tx error cause positions
  localparam int unsigned SQE_TEST_ERROR_BIT = 0;
  localparam int unsigned CARRIER_LOSS_ERROR_BIT = 1;
  localparam int unsigned LATE_COLLISION_ERROR_BIT = 2;
  localparam int unsigned EXCESS_COLLISION_ERROR_BIT = 3;

  localparam logic [FLAG_W-1:0] INTERRUPT_ENABLE_MASK_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] EVENT_FLAG_RESET = 8'h04;

  // pulses and levels from the protocol handler
  typedef struct packed {
    logic link_transition;
    logic counter_rollover;
    logic counter_reg_read;
    logic transmit_enable_write;
    logic fatal_tx_error;
    logic [TX_CAUSE_W-1:0] tx_error_cause;
    logic tx_done;
  } protocol_event_type;

  typedef struct packed {
    logic link_error_gate;
    logic counter_rollover_gate;
    logic transmit_error_gate;
  } protocol_gate_type;

  typedef struct packed {
    logic overrun;
    logic too_long;
    logic receive_discard_bit;
  } receive_abort_type;

  typedef struct packed {
    logic allocation_failed;
    logic tx_queue_empty;
    logic completion_queue_empty;
    logic receive_queue_empty;
  } queue_state_type;

endpackage : mac_irq_pkg

/* core/phy_status_latch.sv */
// latches the phy serial status bits on any change, releases on read
// assumes the status vector is produced on clk_i
`timescale 1ns/1ns
`default_nettype none
module phy_status_latch #(
  parameter int unsigned WIDTH = mac_irq_pkg::PHY_STATUS_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] live_i,
  input wire logic read_i,
  output logic [WIDTH-1:0] latched_o,
  output logic change_o
);

  initial begin
    if (WIDTH < 1) begin
      $error("phy_status_latch: WIDTH must be at least one");
    end
  end

  logic held_q;
  logic seen_q;
  logic [WIDTH-1:0] latched_q;

  // first capture after a read freezes the value until the next read
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      latched_q <= '0;
      held_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (read_i) begin
      latched_q <= live_i;
      held_q <= 1'b0;
      seen_q <= 1'b1;
    end else if (!seen_q) begin
      latched_q <= live_i;
      seen_q <= 1'b1;
    end else if (!held_q && live_i != latched_q) begin
      latched_q <= live_i;
      held_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      change_o <= 1'b0;
    end else begin
      change_o <= seen_q && !held_q && !read_i && live_i != latched_q;
    end
  end

  assign latched_o = latched_q;

  AST_HOLD_UNTIL_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    held_q && !read_i |=> $stable(latched_q))
    else $error("latched phy status moved while held");

endmodule // phy_status_latch
`default_nettype wire

/* core/mac_interrupt_logic.sv */
// interrupt flags, enable mask, acknowledge and request output of the mac
// assumes host byte strobes on clk_i, event sources on clk_i from mac logic
//
// Overview of operation
// - each mask bit enables its flag when high; mask clears on reset
// - mask register is reachable as a word or as single bytes
// - request is asserted while any flag and its mask bit are both set
// - phy change flag sets when any of nine phy status bits change
// - phy status bits latch on change, reads refresh them to present values
// - phy change flag clears only on an acknowledge write with its bit
// - protocol exception merges link transition, counter rollover, fatal tx error
// - fatal tx error drops tx success and reports one of four causes
// - each protocol exception source has its own gate bit
// - exception clears by link gate off, counter read, or tx enable set
// - receive abort sets on overrun, over-long frame, or discard bit
// - receive abort stays latched until acknowledged
// - allocation done is the inverse of allocation failure, one cycle later
// - memory manager clears allocation done on next request or failure
// - tx drained sets when tx queue goes empty, held until acknowledged
// - tx complete is the inverse of completion queue empty
// - acknowledging tx complete removes the completion event
// - receive pending is the inverse of receive queue empty
// - write-only acknowledge shares the offset of the read-only flag register
// - flags reset to zero except tx drained, which resets to one
`timescale 1ns/1ns
`default_nettype none
module mac_interrupt_logic #(
  parameter int unsigned PHY_STATUS_W = mac_irq_pkg::PHY_STATUS_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [mac_irq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [1:0] byte_en_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [mac_irq_pkg::DATA_W-1:0] wdata_i,
  output logic [mac_irq_pkg::DATA_W-1:0] rdata_o,
  input wire logic [PHY_STATUS_W-1:0] phy_status_live_i,
  input wire logic phy_status_read_i,
  output logic [PHY_STATUS_W-1:0] phy_status_o,
  input wire mac_irq_pkg::protocol_event_type protocol_event_i,
  input wire mac_irq_pkg::protocol_gate_type protocol_gate_i,
  input wire mac_irq_pkg::receive_abort_type receive_abort_i,
  input wire mac_irq_pkg::queue_state_type queue_state_i,
  output logic transmit_enable_bit_o,
  output logic transmit_success_bit_o,
  output logic [mac_irq_pkg::TX_CAUSE_W-1:0] tx_error_cause_o,
  output logic completion_pop_o,
  output logic irq_o
);

  localparam int unsigned FW = mac_irq_pkg::FLAG_W;

  initial begin
    if (PHY_STATUS_W != mac_irq_pkg::PHY_STATUS_W) begin
      $error("mac_interrupt_logic: phy status width must be nine");
    end
  end

  // decodes a byte lane hit at the given byte offset
  function automatic logic lane_hit(input logic [mac_irq_pkg::ADDR_W-1:0] addr,
                                    input logic [1:0] be,
                                    input logic [mac_irq_pkg::ADDR_W-1:0] offset);
    lane_hit = (addr[mac_irq_pkg::ADDR_W-1:1] == offset[mac_irq_pkg::ADDR_W-1:1])
               && be[offset[0]];
  endfunction

  logic ack_wr;
  logic mask_wr;
  logic flag_rd;
  logic mask_rd;
  logic [FW-1:0] ack_bits;

  assign ack_wr = wr_i && lane_hit(addr_i, byte_en_i, mac_irq_pkg::EVENT_FLAG_OFFSET);
  assign mask_wr = wr_i && lane_hit(addr_i, byte_en_i,
                                    mac_irq_pkg::INTERRUPT_ENABLE_MASK_OFFSET);
  assign flag_rd = rd_i && lane_hit(addr_i, byte_en_i, mac_irq_pkg::EVENT_FLAG_OFFSET);
  assign mask_rd = rd_i && lane_hit(addr_i, byte_en_i,
                                    mac_irq_pkg::INTERRUPT_ENABLE_MASK_OFFSET);
  assign ack_bits = ack_wr ? wdata_i[FW-1:0] : '0;

  // enable mask
  logic [FW-1:0] interrupt_enable_mask_q;

  // reserved bit is stored as written; the flag behind it never sets
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      interrupt_enable_mask_q <= mac_irq_pkg::INTERRUPT_ENABLE_MASK_RESET;
    end else if (mask_wr) begin
      interrupt_enable_mask_q <= wdata_i[2*FW-1:FW];
    end
  end

  // phy status change
  logic phy_change;
  logic phy_status_change_flag_q;

  phy_status_latch #(
    .WIDTH(PHY_STATUS_W)
  ) u_phy_latch (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .live_i(phy_status_live_i),
    .read_i(phy_status_read_i),
    .latched_o(phy_status_o),
    .change_o(phy_change)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phy_status_change_flag_q <= 1'b0;
    end else if (phy_change) begin
      phy_status_change_flag_q <= 1'b1;
    end else if (ack_bits[mac_irq_pkg::PHY_STATUS_CHANGE_BIT]) begin
      phy_status_change_flag_q <= 1'b0;
    end
  end

  // protocol exception: one sticky cause per source
  logic link_cause_q;
  logic rollover_cause_q;
  logic tx_error_cause_q;
  logic fatal_tx;

  assign fatal_tx = protocol_event_i.fatal_tx_error;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      link_cause_q <= 1'b0;
    end else if (!protocol_gate_i.link_error_gate) begin
      link_cause_q <= 1'b0;
    end else if (protocol_event_i.link_transition) begin
      link_cause_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rollover_cause_q <= 1'b0;
    end else if (protocol_event_i.counter_rollover && protocol_gate_i.counter_rollover_gate) begin
      rollover_cause_q <= 1'b1;
    end else if (protocol_event_i.counter_reg_read) begin
      rollover_cause_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_error_cause_q <= 1'b0;
    end else if (fatal_tx && protocol_gate_i.transmit_error_gate) begin
      tx_error_cause_q <= 1'b1;
    end else if (protocol_event_i.transmit_enable_write) begin
      tx_error_cause_q <= 1'b0;
    end
  end

  // a fatal error forces transmit off and success low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      transmit_enable_bit_o <= 1'b0;
      transmit_success_bit_o <= 1'b0;
      tx_error_cause_o <= '0;
    end else if (fatal_tx) begin
      transmit_enable_bit_o <= 1'b0;
      transmit_success_bit_o <= 1'b0;
      tx_error_cause_o <= protocol_event_i.tx_error_cause;
    end else begin
      if (protocol_event_i.transmit_enable_write) begin
        transmit_enable_bit_o <= 1'b1;
      end
      if (protocol_event_i.tx_done) begin
        transmit_success_bit_o <= 1'b1;
        tx_error_cause_o <= '0;
      end
    end
  end

  // receive abort
  logic receive_abort_flag_q;
  logic abort_event;

  assign abort_event = receive_abort_i.overrun || receive_abort_i.too_long
                       || receive_abort_i.receive_discard_bit;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      receive_abort_flag_q <= 1'b0;
    end else if (abort_event) begin
      receive_abort_flag_q <= 1'b1;
    end else if (ack_bits[mac_irq_pkg::RECEIVE_ABORT_BIT]) begin
      receive_abort_flag_q <= 1'b0;
    end
  end

  // tx drained: edge of the queue empty level
  logic tx_empty_prev_q;
  logic tx_drained_flag_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_empty_prev_q <= 1'b1;
    end else begin
      tx_empty_prev_q <= queue_state_i.tx_queue_empty;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_drained_flag_q <= mac_irq_pkg::EVENT_FLAG_RESET[mac_irq_pkg::TX_DRAINED_BIT];
    end else if (queue_state_i.tx_queue_empty && !tx_empty_prev_q) begin
      tx_drained_flag_q <= 1'b1;
    end else if (ack_bits[mac_irq_pkg::TX_DRAINED_BIT]) begin
      tx_drained_flag_q <= 1'b0;
    end
  end

  // queue-mirror flags follow their sources one cycle later
  logic allocation_done_flag_q;
  logic tx_complete_flag_q;
  logic receive_pending_flag_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      allocation_done_flag_q <= 1'b0;
      tx_complete_flag_q <= 1'b0;
      receive_pending_flag_q <= 1'b0;
    end else begin
      allocation_done_flag_q <= !queue_state_i.allocation_failed;
      tx_complete_flag_q <= !queue_state_i.completion_queue_empty;
      receive_pending_flag_q <= !queue_state_i.receive_queue_empty;
    end
  end

  // removal of a serviced completion entry; the mmu pops its queue
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      completion_pop_o <= 1'b0;
    end else begin
      completion_pop_o <= ack_bits[mac_irq_pkg::TX_COMPLETE_BIT]
                          && !queue_state_i.completion_queue_empty;
    end
  end

  // assembled flag byte
  logic [FW-1:0] event_flag_register;

  always_comb begin
    event_flag_register = '0;
    event_flag_register[mac_irq_pkg::PHY_STATUS_CHANGE_BIT] = phy_status_change_flag_q;
    event_flag_register[mac_irq_pkg::PROTOCOL_EXCEPTION_BIT] =
      link_cause_q || rollover_cause_q || tx_error_cause_q;
    event_flag_register[mac_irq_pkg::RECEIVE_ABORT_BIT] = receive_abort_flag_q;
    event_flag_register[mac_irq_pkg::ALLOCATION_DONE_BIT] = allocation_done_flag_q;
    event_flag_register[mac_irq_pkg::TX_DRAINED_BIT] = tx_drained_flag_q;
    event_flag_register[mac_irq_pkg::TX_COMPLETE_BIT] = tx_complete_flag_q;
    event_flag_register[mac_irq_pkg::RECEIVE_PENDING_BIT] = receive_pending_flag_q;
  end

  // interrupt request, one register stage after the flags
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(event_flag_register & interrupt_enable_mask_q);
    end
  end

  // read data one cycle after the strobe; unselected lanes read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= {(mask_rd ? interrupt_enable_mask_q : 8'h00),
                  (flag_rd ? event_flag_register : 8'h00)};
    end
  end

  AST_IRQ_FROM_FLAGS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    |(event_flag_register & interrupt_enable_mask_q) |=> irq_o)
    else $error("request missing with an enabled flag set");

  AST_IRQ_MASKED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (interrupt_enable_mask_q == 8'h00) |=> !irq_o)
    else $error("request raised with an all-zero mask");

  AST_MASK_BYTE_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mask_wr |=> interrupt_enable_mask_q == $past(wdata_i[15:8]))
    else $error("mask byte write not stored");

  AST_PHY_ACK_ONLY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    phy_status_change_flag_q && !ack_bits[7] |=> phy_status_change_flag_q)
    else $error("phy change flag cleared without acknowledge");

  AST_ABORT_SET_WINS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    abort_event && ack_bits[4] |=> receive_abort_flag_q)
    else $error("abort event lost to acknowledge");

  AST_ABORT_ACK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !abort_event && ack_bits[4] |=> !receive_abort_flag_q)
    else $error("abort flag survived acknowledge");

  AST_DRAINED_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_drained_flag_q && !ack_bits[2] |=> tx_drained_flag_q)
    else $error("drained flag dropped without acknowledge");

  AST_TX_COMPLETE_MIRROR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 tx_complete_flag_q == !$past(queue_state_i.completion_queue_empty))
    else $error("tx complete not inverse of completion empty");

  AST_ALLOC_MIRROR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 allocation_done_flag_q == !$past(queue_state_i.allocation_failed))
    else $error("allocation done not inverse of failure");

  AST_RX_PENDING_MIRROR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    queue_state_i.receive_queue_empty ##1 queue_state_i.receive_queue_empty
    |-> !receive_pending_flag_q)
    else $error("receive pending set on empty queue");

  AST_FATAL_TX: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fatal_tx |=> !transmit_enable_bit_o && !transmit_success_bit_o)
    else $error("fatal tx error left transmit enabled or successful");

  AST_TX_ERR_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    protocol_event_i.transmit_enable_write && !fatal_tx |=> !tx_error_cause_q)
    else $error("tx error cause not cleared by transmit enable");

  AST_LINK_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !protocol_gate_i.link_error_gate |=> !link_cause_q)
    else $error("link cause held with gate off");

  AST_COMPLETION_POP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ack_bits[1] && !queue_state_i.completion_queue_empty |=> completion_pop_o)
    else $error("tx complete acknowledge did not pop");

endmodule // mac_interrupt_logic
`default_nettype wire

/* tb/host_bus_model.sv */
// host processor model for the byte-lane register bus of the interrupt logic
// assumes clk_i is the system clock; requests launch and release on falling edges
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input wire logic clk_i,
  output logic [mac_irq_pkg::ADDR_W-1:0] addr_o,
  output logic [1:0] byte_en_o,
  output logic wr_o,
  output logic rd_o,
  output logic [mac_irq_pkg::DATA_W-1:0] wdata_o
);
  initial begin
    addr_o = 4'h0;
    byte_en_o = 2'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end

  // one access: held across the taking rising edge, released at the next fall
  task automatic access(input logic [3:0] addr, input logic [1:0] be, input logic wr,
                        input logic [15:0] data);
    @(negedge clk_i);
    addr_o <= addr;
    byte_en_o <= be;
    wr_o <= wr;
    rd_o <= !wr;
    wdata_o <= data & 16'hbfbf;
    @(negedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    byte_en_o <= 2'h0;
    // undriven data must not look like the last value
    wdata_o <= ~data;
  endtask
endmodule // host_bus_model
`default_nettype wire

/* tb/mac_interrupt_logic_bench.sv */
// self-checking bench for the mac interrupt logic
// assumes host_bus_model drives the register bus; event sources driven here
`timescale 1ns/1ns
`default_nettype none
module mac_interrupt_logic_bench;
  logic clk_i = 1'b0;
  logic sys_rst_i;
  logic [mac_irq_pkg::ADDR_W-1:0] addr;
  logic [1:0] be;
  logic wr;
  logic rd;
  logic [mac_irq_pkg::DATA_W-1:0] wdata;
  logic [mac_irq_pkg::DATA_W-1:0] rdata;
  logic [8:0] phy_live;
  logic phy_read;
  logic [8:0] phy_stat;
  mac_irq_pkg::protocol_event_type pe;
  mac_irq_pkg::protocol_gate_type pg;
  mac_irq_pkg::receive_abort_type ra;
  mac_irq_pkg::queue_state_type qs;
  logic tx_en;
  logic transmit_success_bit;
  logic [3:0] cause;
  logic pop;
  logic irq;
  int fails = 0;
  int checks = 0;
  int pops = 0;
  int cycles = 0;

  always #50 clk_i = ~clk_i;

  host_bus_model i_host_bus_model (.clk_i(clk_i), .addr_o(addr), .byte_en_o(be),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  mac_interrupt_logic i_mac_interrupt_logic (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr), .byte_en_i(be), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
    .phy_status_live_i(phy_live), .phy_status_read_i(phy_read), .phy_status_o(phy_stat),
    .protocol_event_i(pe), .protocol_gate_i(pg), .receive_abort_i(ra), .queue_state_i(qs),
    .transmit_enable_bit_o(tx_en), .transmit_success_bit_o(transmit_success_bit),
    .tx_error_cause_o(cause), .completion_pop_o(pop), .irq_o(irq));

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a run of a few hundred cycles; a hang ends here at cycle 5000
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (pop === 1'b1) pops <= pops + 1;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic flags_are(input logic [7:0] exp);
    i_host_bus_model.access(4'hc, 2'b01, 1'b0, 16'h0000);
    check(rdata, {8'h00, exp});
  endtask

  task automatic irq_is(input logic exp);
    check({15'h0000, irq}, {15'h0000, exp});
  endtask

  task automatic ack(input logic [7:0] b);
    i_host_bus_model.access(4'hc, 2'b01, 1'b1, {8'h00, b});
  endtask

  task automatic set_mask(input logic [7:0] m);
    i_host_bus_model.access(4'hd, 2'b10, 1'b1, {m, 8'h00});
  endtask

  // bits: 9 link, 8 rollover, 7 counter read, 6 tx enable write, 5 fatal, 4:1 cause, 0 done
  task automatic pulse(input logic [9:0] v);
    @(negedge clk_i);
    pe = mac_irq_pkg::protocol_event_type'(v);
    @(negedge clk_i);
    pe = '0;
  endtask

  task automatic test_reset();
    flags_are(8'h04);
    i_host_bus_model.access(4'hd, 2'b10, 1'b0, 16'h0000);
    check(rdata, 16'h0000);
    irq_is(1'b0);
    ack(8'h04);
    flags_are(8'h00);
  endtask

  task automatic test_mask();
    set_mask(8'hff);
    i_host_bus_model.access(4'hd, 2'b10, 1'b0, 16'h0000);
    check(rdata, 16'hbf00);
    i_host_bus_model.access(4'hc, 2'b11, 1'b1, 16'h1200);
    i_host_bus_model.access(4'hc, 2'b11, 1'b0, 16'h0000);
    check(rdata, 16'h1200);
    i_host_bus_model.access(4'h4, 2'b11, 1'b0, 16'h0000);
    check(rdata, 16'h0000);
  endtask

  task automatic test_abort();
    set_mask(8'h10);
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_i);
      ra = mac_irq_pkg::receive_abort_type'(3'b100 >> i);
      @(negedge clk_i);
      ra = '0;
      tick(4);
      flags_are(8'h10);
      irq_is(1'b1);
      ack(8'h10);
      flags_are(8'h00);
      tick(1);
      irq_is(1'b0);
    end
    set_mask(8'h00);
    ra.overrun = 1'b1;
    tick(1);
    ra = '0;
    tick(2);
    irq_is(1'b0);
    flags_are(8'h10);
    // acknowledge lands in the same cycle as a fresh overrun
    fork
      ack(8'h10);
      begin
        @(negedge clk_i);
        ra.overrun = 1'b1;
        @(negedge clk_i);
        ra.overrun = 1'b0;
      end
    join
    flags_are(8'h10);
    ack(8'h10);
    flags_are(8'h00);
  endtask

  task automatic test_mirror();
    set_mask(8'h0b);
    for (int b = 0; b < 4; b++) begin
      if (b != 2) begin
        qs = mac_irq_pkg::queue_state_type'(4'hf ^ (4'h1 << b));
        tick(2);
        flags_are(8'h01 << b);
        irq_is(1'b1);
        qs = mac_irq_pkg::queue_state_type'(4'hf);
        tick(2);
        flags_are(8'h00);
      end
    end
    irq_is(1'b0);
  endtask

  task automatic test_txdone();
    int p0;
    qs.completion_queue_empty = 1'b0;
    tick(2);
    p0 = pops;
    ack(8'h02);
    tick(2);
    check(16'(pops - p0), 16'h0001);
    qs.completion_queue_empty = 1'b1;
    tick(2);
    p0 = pops;
    ack(8'h02);
    tick(2);
    check(16'(pops - p0), 16'h0000);
  endtask

  task automatic test_drained();
    // every source but drained open: a lone drained flag must not raise the request
    set_mask(8'hbb);
    qs.tx_queue_empty = 1'b0;
    tick(2);
    qs.tx_queue_empty = 1'b1;
    tick(2);
    flags_are(8'h04);
    tick(3);
    flags_are(8'h04);
    irq_is(1'b0);
    // old empty condition acknowledged before the mask is opened
    ack(8'h04);
    set_mask(8'h04);
    flags_are(8'h00);
    irq_is(1'b0);
    qs.tx_queue_empty = 1'b0;
    tick(2);
    qs.tx_queue_empty = 1'b1;
    tick(3);
    irq_is(1'b1);
    ack(8'h04);
    set_mask(8'h00);
  endtask

  task automatic test_phy();
    logic [8:0] frozen;
    for (int i = 0; i < 9; i++) begin
      phy_live = phy_live ^ (9'h001 << i);
      tick(3);
      flags_are(8'h80);
      // later changes while held must not reach the latched copy
      frozen = phy_live;
      phy_live = ~phy_live;
      tick(2);
      check({7'h00, phy_stat}, {7'h00, frozen});
      phy_read = 1'b1;
      tick(1);
      phy_read = 1'b0;
      tick(1);
      check({7'h00, phy_stat}, {7'h00, phy_live});
      flags_are(8'h80);
      ack(8'h80);
      flags_are(8'h00);
    end
  endtask

  task automatic test_exception();
    set_mask(8'h20);
    pg.link_error_gate = 1'b1;
    pulse(10'h200);
    tick(1);
    flags_are(8'h20);
    irq_is(1'b1);
    pg.link_error_gate = 1'b0;
    tick(2);
    flags_are(8'h00);
    pulse(10'h200);
    tick(1);
    flags_are(8'h00);
    pg.counter_rollover_gate = 1'b1;
    pulse(10'h100);
    tick(1);
    flags_are(8'h20);
    pulse(10'h080);
    tick(1);
    flags_are(8'h00);
    pg.counter_rollover_gate = 1'b0;
    pulse(10'h100);
    tick(1);
    flags_are(8'h00);
    pg.transmit_error_gate = 1'b1;
    for (int k = 0; k < 4; k++) begin
      pulse(10'h040);
      pulse(10'h001);
      check({14'h0000, tx_en, transmit_success_bit}, 16'h0003);
      pulse(10'h020 | (10'h002 << k));
      tick(1);
      flags_are(8'h20);
      check({tx_en, transmit_success_bit, 10'h000, cause}, {12'h000, 4'h1 << k});
      pulse(10'h040);
      tick(1);
      flags_are(8'h00);
      check({15'h0000, tx_en}, 16'h0001);
    end
    pg.transmit_error_gate = 1'b0;
    pulse(10'h022);
    tick(1);
    flags_are(8'h00);
  endtask

  initial begin
    sys_rst_i = 1'b1;
    phy_live = 9'h000;
    phy_read = 1'b0;
    pe = '0;
    pg = '0;
    ra = '0;
    qs = mac_irq_pkg::queue_state_type'(4'hf);
    tick(8);
    sys_rst_i = 1'b0;
    test_reset();
    test_mask();
    test_abort();
    test_mirror();
    test_txdone();
    test_drained();
    test_phy();
    test_exception();
    give_verdict();
  end
endmodule // mac_interrupt_logic_bench
`default_nettype wire
